// >>> hdl/snv_top.v
/*
 * SPI slave front end of a 2048 x 8 nonvolatile memory: pin
 * synchronisers, byte framing, opcode decode, write latch, status
 * byte, block guard and pin guard, plus the write FIFO module.
 * Assumes the serial clock is far slower than clk (at least 4 clk
 * periods per serial phase) so every serial edge is seen.
 */
//
// Overview of operation
// - 2048 bytes, each at an 11-bit address
// - two address bytes, top five bits ignored
// - clock level at select fall picks mode
// - first bit on first rising edge
// - bytes MSB first, sample rise, drive fall
// - first byte is command, one per select
// - 06h sets latch, 04h clears latch
// - 05h shifts out the status byte
// - 01h takes one byte as new status
// - 03h reads memory, 02h writes memory
// - latch clear after reset; set before writes
// - completed write clears the latch
// - clear-latch command blocks all writes
// - status bits 7,3,2,1 used; others zero
// - latch flag is read only
// - guard bits kept across power cycles
// - block guard code picks protected range
// - memory write needs latch and unguarded address
// - pin guard on: low pin refuses status write
// - protect pin never blocks memory writes
// - writes finish in transfer, never busy
// - select high: standby, output floats
// - pause low: suspend, ignore edges, float
// - sequential address increments, wraps 7FFh
`timescale 1ns/1ps
`include "snv_consts.vh"

// Synchronous FIFO with valid and ready on both sides
module snv_fifo #(
	parameter WIDTH = `SNV_FIFO_WIDTH,
	parameter DEPTH = `SNV_FIFO_DEPTH,
	parameter AW = `SNV_FIFO_AW
) (
	input wire clk,
	input wire clk_en,
	input wire srst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] store_ff [0:DEPTH-1]; // Entry storage
	reg [AW:0] wr_ptr_ff; // Extra bit tells full from empty
	reg [AW:0] rd_ptr_ff;
	wire full;
	wire empty;
	wire push;
	wire pop;

	assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
		(wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign empty = (wr_ptr_ff == rd_ptr_ff);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = store_ff[rd_ptr_ff[AW-1:0]];
	assign push = in_valid & ~full & clk_en;
	assign pop = out_ready & ~empty & clk_en;

	// Entry write; storage needs no reset, pointers guard it
	always @(posedge clk)
	begin
		if (push)
			store_ff[wr_ptr_ff[AW-1:0]] <= in_data;
	end

	// Pointer update
	always @(posedge clk)
	begin
		if (srst)
		begin
			wr_ptr_ff <= {(AW+1){1'b0}};
			rd_ptr_ff <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end
endmodule

// Device top: serial pins on one side, array and status inside
module snv_top #(
	parameter ADDR_W = `SNV_ADDR_W,
	parameter WORDS = `SNV_MEM_WORDS
) (
	input wire clk,
	input wire clk_en,
	input wire srst,
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire hold_n,
	input wire wp_n,
	output wire so,
	output wire so_oe,
	output wire spi_mode3
);
	localparam ST_CMD = 3'h0; // Taking the opcode
	localparam ST_ADDR_HI = 3'h1; // Upper address byte
	localparam ST_ADDR_LO = 3'h2; // Lower address byte
	localparam ST_MEM_WR = 3'h3; // Write data bytes
	localparam ST_MEM_RD = 3'h4; // Read data bytes
	localparam ST_STAT_RD = 3'h5; // Status byte going out
	localparam ST_STAT_WR = 3'h6; // Status byte coming in
	localparam ST_IDLE = 3'h7; // Frame done or ignored
	// Synchronisers reset to the pins' idle levels: no false edge
	localparam [4:0] SYNC_IDLE = `SNV_PIN_IDLE;

	// Block guard decode, shared by the write gate
	function prot_hit;
		input [1:0] code;
		input [ADDR_W-1:0] addr;
		begin
			case (code)
			`SNV_BG_NONE: prot_hit = 1'b0;
			`SNV_BG_QUARTER: prot_hit = (addr >= `SNV_BG_QUARTER_BASE);
			`SNV_BG_HALF: prot_hit = (addr >= `SNV_BG_HALF_BASE);
			default: prot_hit = 1'b1;
			endcase
		end
	endfunction

	reg [7:0] mem_ff [0:WORDS-1]; // The array
	wire [4:0] pin_raw; // Pins entering the clk domain
	reg [4:0] sync1_ff; // First stage, read by stage two only
	reg [4:0] sync2_ff; // Second stage, safe to use
	reg sck_prev_ff; // Last synced clock level
	reg sel_ff; // Effective select, frozen during pause
	reg mode3_ff; // Mode seen at select fall
	reg [2:0] state_ff; // Frame phase
	reg [2:0] bit_cnt_ff; // Input bits in current byte
	reg [6:0] sh_in_ff; // Input shift bits
	reg [ADDR_W-1:0] addr_ff; // Byte address
	reg [2:0] addr_hi_ff; // Kept low bits of the upper byte
	reg latch_ff; // Write enable latch
	// {pin guard, upper, lower}: power-up value only, srst keeps it
	reg [2:0] nv_ff = `SNV_NV_INIT;
	reg wr_done_ff; // Memory write frame had the latch set
	reg wr_cmd_ff; // Frame carries the memory write opcode
	reg stat_sent_ff; // Status byte fully shifted out
	reg tx_act_ff; // Output phase running
	reg [2:0] out_cnt_ff; // Output bits sent of current byte
	reg [6:0] tx_sh_ff; // Remaining output bits
	reg so_ff; // Output bit on the pin
	reg [7:0] rd_data_ff; // Fetched array byte
	reg fetch_ff; // One-cycle array read, stalls the drain
	reg pend_vld_ff; // Write held for the FIFO
	reg [`SNV_FIFO_WIDTH-1:0] pend_ff; // {address, data}
	wire sck_s;
	wire cs_s;
	wire si_s;
	wire hold_s;
	wire wp_s;
	wire run; // Pause released
	wire rise;
	wire fall;
	wire [7:0] byte_in;
	wire byte_done;
	wire [7:0] status;
	wire st_refused;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`SNV_FIFO_WIDTH-1:0] fifo_out_data;
	wire drain_ready;

	assign pin_raw = {wp_n, hold_n, si, cs_n, sck};

	// Two flip-flops per pin before any logic looks at it
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1)
		begin : g_sync
			always @(posedge clk)
			begin
				if (srst)
				begin
					sync1_ff[gi] <= SYNC_IDLE[gi];
					sync2_ff[gi] <= SYNC_IDLE[gi];
				end
				else if (clk_en)
				begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	assign sck_s = sync2_ff[0];
	assign cs_s = sync2_ff[1];
	assign si_s = sync2_ff[2];
	assign hold_s = sync2_ff[3];
	assign wp_s = sync2_ff[4];
	// Pause freezes the frame but not the sampled clock history
	assign run = hold_s;
	assign rise = run & sel_ff & sck_s & ~sck_prev_ff;
	assign fall = run & sel_ff & ~sck_s & sck_prev_ff;
	assign byte_in = {sh_in_ff, si_s};
	assign byte_done = rise & (bit_cnt_ff == 3'h7);
	// Unused bits read zero; latch flag mirrors the latch
	assign status = {nv_ff[2], 3'h0, nv_ff[1:0], latch_ff, 1'b0};
	// Pin guard only touches status writes
	assign st_refused = nv_ff[2] & ~wp_s;
	assign spi_mode3 = mode3_ff;
	// Output floats outside a read phase, in standby and in pause
	assign so_oe = sel_ff & run & tx_act_ff;
	assign so = so_ff;
	// Array port is single: the drain yields to a read fetch
	assign drain_ready = ~fetch_ff;

	snv_fifo #(
		.WIDTH(`SNV_FIFO_WIDTH),
		.DEPTH(`SNV_FIFO_DEPTH),
		.AW(`SNV_FIFO_AW)
	) u_wr_fifo (
		.clk(clk),
		.clk_en(clk_en),
		.srst(srst),
		.in_valid(pend_vld_ff),
		.in_ready(fifo_in_ready),
		.in_data(pend_ff),
		.out_valid(fifo_out_valid),
		.out_ready(drain_ready),
		.out_data(fifo_out_data)
	);

	// Array port: drain writes, or fetch a read byte
	always @(posedge clk)
	begin
		if (clk_en)
		begin
			if (fetch_ff)
				rd_data_ff <= mem_ff[addr_ff];
			else if (fifo_out_valid)
				mem_ff[fifo_out_data[18:8]] <= fifo_out_data[7:0];
		end
	end

	// Select tracking, mode capture and clock history
	always @(posedge clk)
	begin
		if (srst)
		begin
			sck_prev_ff <= 1'b0;
			sel_ff <= 1'b0;
			mode3_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			sck_prev_ff <= sck_s;
			// Select changes are ignored while paused
			if (run)
			begin
				sel_ff <= ~cs_s;
				if (~cs_s & ~sel_ff)
					mode3_ff <= sck_s;
			end
		end
	end

	// Frame sequencer, latch, status and write queue
	always @(posedge clk)
	begin
		if (srst)
		begin
			state_ff <= ST_CMD;
			bit_cnt_ff <= 3'h0;
			sh_in_ff <= 7'h00;
			addr_ff <= `SNV_ADDR_ZERO;
			addr_hi_ff <= 3'h0;
			latch_ff <= 1'b0;
			wr_done_ff <= 1'b0;
			wr_cmd_ff <= 1'b0;
			pend_vld_ff <= 1'b0;
			pend_ff <= {`SNV_FIFO_WIDTH{1'b0}};
			fetch_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			fetch_ff <= 1'b0;
			// A held write leaves once the FIFO takes it
			if (pend_vld_ff & fifo_in_ready)
				pend_vld_ff <= 1'b0;
			if (~sel_ff)
			begin
				// Standby: frame resets, write frame ends here
				state_ff <= ST_CMD;
				bit_cnt_ff <= 3'h0;
				if (wr_done_ff)
					latch_ff <= 1'b0;
				wr_done_ff <= 1'b0;
				wr_cmd_ff <= 1'b0;
			end
			else if (rise)
			begin
				// Sample on the rising edge, MSB first
				sh_in_ff <= byte_in[6:0];
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
			end
			if (sel_ff & byte_done)
			begin
				case (state_ff)
				ST_CMD:
				begin
					case (byte_in)
					`SNV_OP_SET_LATCH:
					begin
						latch_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end
					`SNV_OP_CLR_LATCH:
					begin
						latch_ff <= 1'b0;
						state_ff <= ST_IDLE;
					end
					`SNV_OP_STAT_RD: state_ff <= ST_STAT_RD;
					`SNV_OP_STAT_WR: state_ff <= ST_STAT_WR;
					`SNV_OP_MEM_RD: state_ff <= ST_ADDR_HI;
					`SNV_OP_MEM_WR:
					begin
						state_ff <= ST_ADDR_HI;
						wr_done_ff <= latch_ff;
						wr_cmd_ff <= 1'b1;
					end
					// Unknown opcode: stay silent till next select
					default: state_ff <= ST_IDLE;
					endcase
				end
				// Only the low three bits of the upper byte count
				ST_ADDR_HI:
				begin
					addr_hi_ff <= byte_in[2:0];
					state_ff <= ST_ADDR_LO;
				end
				ST_ADDR_LO:
				begin
					addr_ff <= {addr_hi_ff, byte_in};
					// Reads fetch at once; writes go on only with latch
					if (~wr_cmd_ff)
					begin
						state_ff <= ST_MEM_RD;
						fetch_ff <= 1'b1;
					end
					else if (wr_done_ff)
						state_ff <= ST_MEM_WR;
					else
						state_ff <= ST_IDLE;
				end
				ST_MEM_WR:
				begin
					// Gate is the latch and block guard only
					if (~prot_hit(nv_ff[1:0], addr_ff))
					begin
						pend_vld_ff <= 1'b1;
						pend_ff <= {addr_ff, byte_in};
					end
					addr_ff <= addr_ff + 1'b1;
				end
				ST_STAT_WR:
				begin
					// Refused writes keep storage and latch
					if (latch_ff & ~st_refused)
					begin
						nv_ff <= {byte_in[`SNV_ST_PIN_GUARD],
							byte_in[`SNV_ST_BG_UPPER],
							byte_in[`SNV_ST_BG_LOWER]};
						latch_ff <= 1'b0;
					end
					state_ff <= ST_IDLE;
				end
				default: state_ff <= state_ff;
				endcase
			end
			// Next read byte is fetched after each address step
			if (sel_ff & fall & tx_act_ff & (out_cnt_ff == 3'h7) &
				(state_ff == ST_MEM_RD))
			begin
				addr_ff <= addr_ff + 1'b1;
				fetch_ff <= 1'b1;
			end
		end
	end

	// Output shifter: bits change on the falling edge
	always @(posedge clk)
	begin
		if (srst)
		begin
			tx_act_ff <= 1'b0;
			out_cnt_ff <= 3'h0;
			tx_sh_ff <= 7'h00;
			so_ff <= 1'b0;
			stat_sent_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (~sel_ff)
			begin
				tx_act_ff <= 1'b0;
				out_cnt_ff <= 3'h0;
				stat_sent_ff <= 1'b0;
			end
			else if (byte_done & (((state_ff == ST_CMD) &
				(byte_in == `SNV_OP_STAT_RD)) |
				((state_ff == ST_ADDR_LO) & ~wr_cmd_ff)))
				tx_act_ff <= 1'b1;
			// Last status bit stands until the following fall
			else if (fall & tx_act_ff & stat_sent_ff)
				tx_act_ff <= 1'b0;
			else if (fall & tx_act_ff)
			begin
				out_cnt_ff <= out_cnt_ff + 3'h1;
				if (out_cnt_ff == 3'h0)
				begin
					// New byte: status or the fetched array byte
					if (state_ff == ST_STAT_RD)
					begin
						so_ff <= status[7];
						tx_sh_ff <= status[6:0];
					end
					else
					begin
						so_ff <= rd_data_ff[7];
						tx_sh_ff <= rd_data_ff[6:0];
					end
				end
				else
				begin
					so_ff <= tx_sh_ff[6];
					tx_sh_ff <= {tx_sh_ff[5:0], 1'b0};
				end
				// One status byte only; pin floats at the next fall
				if ((state_ff == ST_STAT_RD) & (out_cnt_ff == 3'h7))
					stat_sent_ff <= 1'b1;
			end
		end
	end
endmodule

// >>> hdl/snv_consts.vh
/*
 * Constants of the serial nonvolatile memory front end: opcodes,
 * status byte layout, protection ranges and array geometry.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef SNV_CONSTS_VH
`define SNV_CONSTS_VH

// Array geometry
`define SNV_ADDR_W 11
`define SNV_MEM_WORDS 2048
`define SNV_ADDR_LAST 11'h7FF
`define SNV_ADDR_ZERO 11'h000

// Opcodes, first byte of a frame
`define SNV_OP_SET_LATCH 8'h06
`define SNV_OP_CLR_LATCH 8'h04
`define SNV_OP_STAT_RD 8'h05
`define SNV_OP_STAT_WR 8'h01
`define SNV_OP_MEM_RD 8'h03
`define SNV_OP_MEM_WR 8'h02

// Status byte bit positions
`define SNV_ST_PIN_GUARD 7
`define SNV_ST_BG_UPPER 3
`define SNV_ST_BG_LOWER 2
`define SNV_ST_LATCH 1

// Power-up value of the nonvolatile guard bits {pin, upper, lower}
`define SNV_NV_INIT 3'h0

// Idle levels of the pins {wp_n, hold_n, si, cs_n, sck}
`define SNV_PIN_IDLE 5'h1A

// Block guard codes and lower bound of the quarter and half guarded ranges
`define SNV_BG_NONE 2'h0
`define SNV_BG_QUARTER 2'h1
`define SNV_BG_HALF 2'h2
`define SNV_BG_ALL 2'h3
`define SNV_BG_QUARTER_BASE 11'h600
`define SNV_BG_HALF_BASE 11'h400

// Write FIFO shape: address plus data, 16 entries
`define SNV_FIFO_WIDTH 19
`define SNV_FIFO_DEPTH 16
`define SNV_FIFO_AW 4

// Link clock in the bench, for reference only
`define SNV_LINK_PERIOD_NS 125

`endif

// >>> test/snv_host.sv
/*
 * Host model: SPI bus master driving select, clock and data in.
 * Assumes so_w is the resolved level of the device's output pin.
 */
`timescale 1ns/1ps
// Master side of the link; the clock only moves within frames
module snv_host (
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire so_w
);
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// One select period; tx holds n bytes in its low bits
	task frame(input bit m3, input int n, input logic [39:0] tx,
		output logic [39:0] rx);
		int k;
		begin
			rx = 40'h0;
			sck = m3; // Idle level tells the mode
			#40 cs_n = 1'b0;
			#40;
			for (k = n * 8 - 1; k >= 0; k--)
			begin
				sck = 1'b0;
				si = tx[k];
				#62.5 sck = 1'b1;
				rx = {rx[38:0], so_w};
				#62.5;
			end
			sck = m3;
			#40 cs_n = 1'b1;
			si = ~si; // A released line must not keep its value
			#60;
		end
	endtask
endmodule

// >>> test/snv_top_asserts.sv
/*
 * Pin-level assertions of the serial memory front end.
 * Assumes a serial clock far slower than clk; clk_en drops only
 * while the link is idle or for a whole frame.
 */
`timescale 1ns/1ps
// Checker that sees only the device pins
module snv_top_asserts (
	input logic clk,
	input logic clk_en,
	input logic srst,
	input logic cs_n,
	input logic sck,
	input logic si,
	input logic hold_n,
	input logic wp_n,
	input logic so,
	input logic so_oe,
	input logic spi_mode3
);
	default clocking snv_cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_reset_quiet: assert property (disable iff (1'b0)
		srst |=> !so_oe && !spi_mode3)
		else $error("Outputs active after reset");
	// Synchronisers need a few cycles before the pin floats
	a_idle_float: assert property (cs_n [*6] |-> !so_oe)
		else $error("Output driven while deselected");
	a_pause_float: assert property (!hold_n [*6] |-> !so_oe)
		else $error("Output driven while paused");
	a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
		else $error("Output kept after select rose");
	a_oe_start: assert property ($rose(so_oe) && $past(hold_n, 5)
		|-> !cs_n && sck && $past(sck, 2))
		else $error("Output enabled away from a rising clock");
	a_so_on_fall: assert property (so_oe && $past(so_oe)
		&& $changed(so) |-> !sck && !$past(sck, 2))
		else $error("Output bit changed away from a falling clock");
	a_mode_pick: assert property ($changed(spi_mode3)
		|-> spi_mode3 == $past(sck, 3) && !$past(cs_n, 2))
		else $error("Mode flag not the clock level at select");
	a_mode_hold: assert property (!cs_n [*5] |=> $stable(spi_mode3))
		else $error("Mode flag moved inside a frame");
endmodule

bind snv_top snv_top_asserts snv_top_asserts_i (.clk(clk),
	.clk_en(clk_en), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
	.hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
	.spi_mode3(spi_mode3));

// >>> test/tb_top.sv
/*
 * Self-checking bench of the serial memory front end.
 * Assumes the host model and the checker are compiled beside it.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	err_count++; $display("Error %s expected %h seen %h", nm, e, g); \
	end end
// Bench top: rows of frames, then pause, opcode and reset cases
module tb_top;
	typedef struct {
		bit m3; bit wp; bit wl; int n;
		logic [39:0] tx; logic [15:0] ex; int w;
	} snv_row_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hold_n = 1'b1;
	logic wp_n = 1'b1;
	logic clk_en = 1'b1;
	wire cs_n, sck, si, so, so_oe, spi_mode3;
	wire so_w; // Pin level seen by the host
	logic [39:0] rx;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int oe_hits = 0;
	// Mode, pin, latch first, bytes, frame, expected, compare width
	snv_row_t rows [31] = '{
		'{0, 1, 0, 2, 40'h0500, 16'h0, 8},
		'{1, 1, 1, 2, 40'h0500, 16'h2, 8},
		'{0, 1, 0, 1, 40'h04, 16'h0, 0},
		'{0, 1, 0, 2, 40'h0500, 16'h0, 8},
		'{0, 1, 1, 5, 40'h02F8105A3C, 16'h0, 0},
		'{0, 1, 0, 2, 40'h0500, 16'h0, 8},
		'{0, 1, 0, 5, 40'h0300100000, 16'h5A3C, 16},
		'{0, 1, 1, 5, 40'h0207FF1122, 16'h0, 0},
		'{0, 1, 0, 5, 40'h0307FF0000, 16'h1122, 16},
		'{0, 1, 0, 4, 40'h02000077, 16'h0, 0},
		'{0, 1, 0, 4, 40'h03000000, 16'h22, 8},
		'{0, 1, 1, 5, 40'h0205FFA1A2, 16'h0, 0},
		'{0, 1, 1, 5, 40'h0203FFB1B2, 16'h0, 0},
		'{0, 1, 1, 2, 40'h0104, 16'h0, 0},
		'{0, 1, 1, 5, 40'h0205FFC1C2, 16'h0, 0},
		'{0, 1, 0, 5, 40'h0305FF0000, 16'hC1A2, 16},
		'{0, 1, 1, 2, 40'h0108, 16'h0, 0},
		'{0, 1, 1, 5, 40'h0203FFD1D2, 16'h0, 0},
		'{0, 1, 0, 5, 40'h0303FF0000, 16'hD1B2, 16},
		'{0, 1, 1, 2, 40'h010C, 16'h0, 0},
		'{0, 1, 1, 4, 40'h02000099, 16'h0, 0},
		'{0, 1, 0, 4, 40'h03000000, 16'h22, 8},
		'{0, 1, 1, 2, 40'h01F3, 16'h0, 0},
		'{0, 1, 0, 2, 40'h0500, 16'h80, 8},
		'{0, 0, 1, 2, 40'h010C, 16'h0, 0},
		'{0, 0, 0, 2, 40'h0500, 16'h82, 8},
		'{0, 0, 0, 4, 40'h0200005E, 16'h0, 0},
		'{0, 0, 0, 4, 40'h03000000, 16'h5E, 8},
		'{0, 1, 1, 2, 40'h0100, 16'h0, 0},
		'{0, 0, 1, 2, 40'h0104, 16'h0, 0},
		'{0, 0, 0, 2, 40'h0500, 16'h4, 8}
	};

	// Floating output reads as the inverse of its last driven bit
	assign so_w = so_oe ? so : ~so;

	always #5 clk = ~clk;

	snv_top snv_top_i (.clk(clk), .clk_en(clk_en), .srst(srst),
		.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
		.wp_n(wp_n), .so(so), .so_oe(so_oe), .spi_mode3(spi_mode3));

	snv_host snv_host_i (.cs_n(cs_n), .sck(sck), .si(si), .so_w(so_w));

	// Prints the counts and the verdict, then stops
	task end_of_test;
		begin
			$display("Checks %0d errors %0d", checks_done, err_count);
			if (err_count == 0 && checks_done > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	// Cycle ceiling against hangs; also counts driven output cycles
	always @(posedge clk)
	begin
		cyc++;
		if (so_oe !== 1'b0)
			oe_hits++;
		if (cyc == 60000)
		begin
			err_count++;
			end_of_test;
		end
	end

	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		foreach (rows[i])
		begin
			@(posedge clk);
			#1 wp_n = rows[i].wp;
			if (rows[i].wl)
				snv_host_i.frame(rows[i].m3, 1, 40'h06, rx);
			snv_host_i.frame(rows[i].m3, rows[i].n, rows[i].tx, rx);
			`CHK("mode", rows[i].m3, spi_mode3)
			if (rows[i].w == 16)
				`CHK("data", rows[i].ex, rx[15:0])
			else if (rows[i].w == 8)
				`CHK("byte", rows[i].ex[7:0], rx[7:0])
		end
		// Paused frame, unknown opcode and a stacked second opcode
		oe_hits = 0;
		@(posedge clk);
		#1 hold_n = 1'b0;
		snv_host_i.frame(0, 2, 40'h0500, rx);
		@(posedge clk);
		#1 hold_n = 1'b1;
		// Clock enable low freezes the device through a whole frame
		repeat (4) @(posedge clk);
		#1 clk_en = 1'b0;
		snv_host_i.frame(0, 2, 40'h0500, rx);
		@(posedge clk);
		#1 clk_en = 1'b1;
		repeat (4) @(posedge clk);
		snv_host_i.frame(0, 2, 40'h0F05, rx);
		// Write without the latch: no output and no store
		snv_host_i.frame(0, 4, 40'h02000033, rx);
		snv_host_i.frame(0, 2, 40'h0605, rx);
		`CHK("output cycles", 0, oe_hits)
		snv_host_i.frame(0, 4, 40'h03000000, rx);
		`CHK("refused byte", 8'h5E, rx[7:0])
		// Reset in mid-run: latch drops, guard bits survive
		@(posedge clk);
		#1 srst = 1'b1;
		repeat (3) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		snv_host_i.frame(0, 2, 40'h0500, rx);
		`CHK("status", 8'h04, rx[7:0])
		end_of_test;
	end
endmodule
